// ==== core/smp_pkg.sv ====
/*
 * Shared constants for the serial master port: register offsets, field
 * positions, reset values, clock divisors and the transfer state encoding.
 * Assumes the host reaches the registers by byte offset within the block.
 */
package smp_pkg;

    // Register offsets within the block's I/O window
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'h9;
    localparam logic [3:0] OFS_DATA0 = 4'ha;
    localparam logic [3:0] OFS_DATA1 = 4'hb;
    localparam logic [3:0] OFS_DATA2 = 4'hc;
    localparam logic [3:0] OFS_DATA3 = 4'hd;
    localparam logic [3:0] OFS_DEBUG = 4'he;

    // Control register fields
    localparam int CTRL_CPOL = 7;
    localparam int CTRL_CPHA = 6;
    localparam int CTRL_LEN_LO = 4;
    localparam int CTRL_MAN = 3;
    localparam int CTRL_SEL_LO = 0;

    // Status/config register fields
    localparam int STAT_INTERRUPT_LINE_SELECT_LO = 6;
    localparam int STAT_CLK_LO = 4;
    localparam int STAT_IRQEN = 3;
    localparam int STAT_LSB = 2;
    localparam int STAT_HWINT = 1;
    localparam int STAT_BUSY = 0;

    // Debug register fields
    localparam int DBG_LOOP = 1;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [5:0] STAT_CFG_RST = 6'h00;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic DBG_LOOP_RST = 1'b0;

    // Serial clock divisors of the host-bus clock for rate codes 00..11
    localparam int HOST_CLK_MHZ = 33;
    localparam int DIV_CODE0 = 32;
    localparam int DIV_CODE1 = 16;
    localparam int DIV_CODE2 = 8;
    localparam int DIV_CODE3 = 4;

    // The peripheral interrupt input is not wired on this product
    localparam logic PERIPH_IRQ_CONNECTED = 1'b0;

    // Write queue
    localparam int WQ_DEPTH = 8;
    localparam int WQ_WIDTH = 12;

    typedef enum logic [1:0] {
        SMP_IDLE = 2'b00,
        SMP_SETUP = 2'b01,
        SMP_RUN = 2'b11,
        SMP_HOLD = 2'b10
    } smp_state_t;

endpackage

// ==== core/smp_fifo.sv ====
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module smp_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } smp_fifo_st_t;

    smp_fifo_st_t q_r;
    smp_fifo_st_t q_nxt;
    logic push;
    logic pop;

    assign o_in_ready = (q_r.cnt != CW'(DEPTH));
    assign o_out_valid = (q_r.cnt != '0);
    assign o_out_data = q_r.mem[q_r.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        q_nxt = q_r;
        if (push) begin
            q_nxt.mem[q_r.wp] = i_in_data;
            q_nxt.wp = (q_r.wp == AW'(DEPTH - 1)) ? '0 : q_r.wp + 1'b1;
        end
        if (pop) begin
            q_nxt.rp = (q_r.rp == AW'(DEPTH - 1)) ? '0 : q_r.rp + 1'b1;
        end
        if (push && !pop) begin
            q_nxt.cnt = q_r.cnt + 1'b1;
        end else if (pop && !push) begin
            q_nxt.cnt = q_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

endmodule // smp_fifo

`default_nettype wire

// ==== core/smp_spi_master_port.sv ====
/*
 * Register-driven serial master: control, status/config, four data bytes
 * and a debug byte, written through an eight-entry write queue and read
 * directly. Shifts frames of 8 to 32 bits to one of seven selects.
 * Assumes the reference clock stands for the host-bus clock the serial
 * clock is divided from, and that all inputs are synchronous to it.
 *
 */
`timescale 1ns/1ps
`default_nettype none

module smp_spi_master_port (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Host register port
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_wr_ready,
    output logic [7:0] o_rdata,
    output logic o_rd_valid,
    // Serial bus
    output logic o_sclk,
    output logic o_mosi,
    input wire logic i_miso,
    output logic [6:0] o_sel_n,
    // Interrupts
    input wire logic i_periph_irq_n,
    output logic [3:0] o_irq_req
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [5:0] stat_cfg;
        logic loop;
        logic [31:0] word;
        smp_pkg::smp_state_t st;
        logic [3:0] div_cnt;
        logic [6:0] edge_cnt;
        logic have_smp;
        logic smp;
        logic sclk;
        logic mosi;
        logic [6:0] sel_n;
        logic [7:0] rdata;
        logic rd_valid;
        logic irq_act;
        logic [3:0] irq_req;
    } smp_port_st_t;

    smp_port_st_t q_r;
    smp_port_st_t q_nxt;

    logic wq_valid;
    logic wq_ready;
    logic [smp_pkg::WQ_WIDTH-1:0] wq_data;

    // Reload value for one half period of the serial clock
    function automatic logic [3:0] half_reload(input logic [1:0] code);
        unique case (code)
            2'b00: half_reload = 4'(smp_pkg::DIV_CODE0 / 2 - 1);
            2'b01: half_reload = 4'(smp_pkg::DIV_CODE1 / 2 - 1);
            2'b10: half_reload = 4'(smp_pkg::DIV_CODE2 / 2 - 1);
            2'b11: half_reload = 4'(smp_pkg::DIV_CODE3 / 2 - 1);
        endcase
    endfunction

    // Active-low one-of-seven select, code 000 selects nothing
    function automatic logic [6:0] sel_decode(input logic [2:0] code);
        logic [7:0] onehot;
        onehot = 8'h01 << code;
        sel_decode = ~onehot[7:1];
    endfunction

    // Shift the frame window [31:lo] one place, taking in bit b
    function automatic logic [31:0] shift_word(input logic [31:0] w, input logic b,
                                               input logic [4:0] lo, input logic lsb);
        logic [31:0] r;
        r = w;
        for (int i = 0; i < 32; i++) begin
            if (!lsb) begin
                if (i > int'(lo)) begin
                    r[i] = w[5'(i - 1)];
                end else if (i == int'(lo)) begin
                    r[i] = b;
                end
            end else begin
                if (i >= int'(lo) && i < 31) begin
                    r[i] = w[5'(i + 1)];
                end else if (i == 31) begin
                    r[i] = b;
                end
            end
        end
        shift_word = r;
    endfunction

    smp_fifo #(
        .WIDTH(smp_pkg::WQ_WIDTH),
        .DEPTH(smp_pkg::WQ_DEPTH)
    ) u_write_queue (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(i_wr),
        .o_in_ready(o_wr_ready),
        .i_in_data({i_addr, i_wdata}),
        .o_out_valid(wq_valid),
        .i_out_ready(wq_ready),
        .o_out_data(wq_data)
    );

    // Register writes are held in the queue until the engine is idle
    assign wq_ready = (q_r.st == smp_pkg::SMP_IDLE);

    always_comb begin
        logic [3:0] waddr;
        logic [7:0] wdat;
        logic start;
        logic lsb;
        logic [1:0] len;
        logic [4:0] lo;
        logic [6:0] total;
        logic rx;
        logic new_lvl;
        logic smp_edge;
        logic busy;
        waddr = wq_data[11:8];
        wdat = wq_data[7:0];
        start = 1'b0;
        lsb = 1'b0;
        len = 2'b00;
        lo = 5'd0;
        total = 7'd0;
        rx = 1'b0;
        new_lvl = 1'b0;
        smp_edge = 1'b0;
        busy = 1'b0;
        q_nxt = q_r;
        q_nxt.rd_valid = 1'b0;

        // Peripheral interrupt, forced inactive when unwired
        q_nxt.irq_act = smp_pkg::PERIPH_IRQ_CONNECTED & ~i_periph_irq_n;
        q_nxt.irq_req = 4'h0;
        if (q_r.stat_cfg[smp_pkg::STAT_IRQEN - 2] && q_r.irq_act) begin
            q_nxt.irq_req[q_r.stat_cfg[5:4]] = 1'b1;
        end

        // Register writes from the queue
        if (wq_valid && wq_ready) begin
            unique case (waddr)
                smp_pkg::OFS_CTRL: q_nxt.ctrl = wdat;
                smp_pkg::OFS_STAT: q_nxt.stat_cfg = wdat[7:2];
                smp_pkg::OFS_DATA0: q_nxt.word[7:0] = wdat;
                smp_pkg::OFS_DATA1: q_nxt.word[15:8] = wdat;
                smp_pkg::OFS_DATA2: q_nxt.word[23:16] = wdat;
                smp_pkg::OFS_DATA3: begin
                    q_nxt.word[31:24] = wdat;
                    start = 1'b1;
                end
                smp_pkg::OFS_DEBUG: q_nxt.loop = wdat[smp_pkg::DBG_LOOP];
                default: ;
            endcase
        end

        lsb = q_nxt.stat_cfg[smp_pkg::STAT_LSB - 2];
        len = q_nxt.ctrl[smp_pkg::CTRL_LEN_LO +: 2];
        lo = 5'({~len, 3'b000});
        total = 7'((32'(len) + 32'd1) * 32'd16);
        rx = q_r.loop ? q_r.mosi : i_miso;

        unique case (q_r.st)
            smp_pkg::SMP_IDLE: begin
                q_nxt.sclk = q_nxt.ctrl[smp_pkg::CTRL_CPOL];
                if (start) begin
                    q_nxt.st = smp_pkg::SMP_SETUP;
                    q_nxt.div_cnt = half_reload(q_nxt.stat_cfg[3:2]);
                    q_nxt.edge_cnt = 7'd0;
                    q_nxt.have_smp = 1'b0;
                    q_nxt.mosi = lsb ? q_nxt.word[lo] : q_nxt.word[31];
                end
            end
            smp_pkg::SMP_SETUP: begin
                if (q_r.div_cnt == 4'd0) begin
                    q_nxt.st = smp_pkg::SMP_RUN;
                    q_nxt.div_cnt = half_reload(q_r.stat_cfg[3:2]);
                end else begin
                    q_nxt.div_cnt = q_r.div_cnt - 4'd1;
                end
            end
            smp_pkg::SMP_RUN: begin
                if (q_r.div_cnt == 4'd0) begin
                    q_nxt.div_cnt = half_reload(q_r.stat_cfg[3:2]);
                    new_lvl = ~q_r.sclk;
                    q_nxt.sclk = new_lvl;
                    q_nxt.edge_cnt = q_r.edge_cnt + 7'd1;
                    smp_edge = (new_lvl == ~q_r.ctrl[smp_pkg::CTRL_CPHA]);
                    if (smp_edge) begin
                        q_nxt.smp = rx;
                        q_nxt.have_smp = 1'b1;
                    end else if (q_r.have_smp) begin
                        q_nxt.word = shift_word(q_r.word, q_r.smp, lo, lsb);
                        q_nxt.mosi = lsb ? q_nxt.word[lo] : q_nxt.word[31];
                        q_nxt.have_smp = 1'b0;
                    end
                    if (q_r.edge_cnt + 7'd1 == total) begin
                        q_nxt.st = smp_pkg::SMP_HOLD;
                        if (smp_edge) begin
                            // Last edge samples: fold the final bit in now
                            q_nxt.word = shift_word(q_r.word, rx, lo, lsb);
                            q_nxt.have_smp = 1'b0;
                        end
                    end
                end else begin
                    q_nxt.div_cnt = q_r.div_cnt - 4'd1;
                end
            end
            smp_pkg::SMP_HOLD: begin
                if (q_r.div_cnt == 4'd0) begin
                    q_nxt.st = smp_pkg::SMP_IDLE;
                    q_nxt.sclk = q_r.ctrl[smp_pkg::CTRL_CPOL];
                end else begin
                    q_nxt.div_cnt = q_r.div_cnt - 4'd1;
                end
            end
        endcase

        // Select lines: software-held in manual mode, transfer-framed otherwise
        if (q_nxt.ctrl[smp_pkg::CTRL_MAN]) begin
            q_nxt.sel_n = sel_decode(q_nxt.ctrl[2:0]);
        end else if (q_nxt.st != smp_pkg::SMP_IDLE) begin
            q_nxt.sel_n = sel_decode(q_nxt.ctrl[2:0]);
        end else begin
            q_nxt.sel_n = 7'h7f;
        end

        // Register reads, answered one cycle later
        busy = (q_r.st != smp_pkg::SMP_IDLE) || wq_valid;
        if (i_rd) begin
            q_nxt.rd_valid = 1'b1;
            unique case (i_addr)
                smp_pkg::OFS_CTRL: q_nxt.rdata = q_r.ctrl;
                smp_pkg::OFS_STAT: q_nxt.rdata = {q_r.stat_cfg, q_r.irq_act, busy};
                smp_pkg::OFS_DATA0: q_nxt.rdata = q_r.word[7:0];
                smp_pkg::OFS_DATA1: q_nxt.rdata = q_r.word[15:8];
                smp_pkg::OFS_DATA2: q_nxt.rdata = q_r.word[23:16];
                smp_pkg::OFS_DATA3: q_nxt.rdata = q_r.word[31:24];
                smp_pkg::OFS_DEBUG: q_nxt.rdata = {6'h00, q_r.loop, 1'b0};
                default: q_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            q_r <= '0;
            q_r.ctrl <= smp_pkg::CTRL_RST;
            q_r.stat_cfg <= smp_pkg::STAT_CFG_RST;
            q_r.loop <= smp_pkg::DBG_LOOP_RST;
            q_r.word <= smp_pkg::DATA_RST;
            q_r.st <= smp_pkg::SMP_IDLE;
            q_r.sel_n <= 7'h7f;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_sclk = q_r.sclk;
    assign o_mosi = q_r.mosi;
    assign o_sel_n = q_r.sel_n;
    assign o_rdata = q_r.rdata;
    assign o_rd_valid = q_r.rd_valid;
    assign o_irq_req = q_r.irq_req;

endmodule // smp_spi_master_port

`default_nettype wire

// ==== testbench/smp_spi_sva.sv ====
/* Port checker for the serial master port.
   Assumes it is bound to smp_spi_master_port and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module smp_spi_sva (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Host side
    input wire logic i_rd,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] o_rdata,
    input wire logic o_rd_valid,
    // Serial side
    input wire logic o_sclk,
    input wire logic o_mosi,
    input wire logic [6:0] o_sel_n,
    input wire logic [3:0] o_irq_req
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_irq_held_low: assert property (
        o_irq_req == 4'h0) else $error("interrupt request raised");
    a_hwint_reads_zero: assert property (
        i_rd && i_addr == smp_pkg::OFS_STAT |=> o_rdata[1] == 1'b0)
        else $error("interrupt flag set");
    a_busy_in_frame: assert property (
        i_rd && i_addr == smp_pkg::OFS_STAT && $changed(o_sclk) && !(&o_sel_n)
        |=> o_rdata[0])
        else $error("busy low during frame");
    a_debug_reserved: assert property (
        i_rd && i_addr == smp_pkg::OFS_DEBUG |=> o_rdata[7] == 1'b0)
        else $error("reserved debug bit set");
    a_one_select: assert property (
        $onehot0(~o_sel_n)) else $error("several selects low");
    a_mosi_steady: assert property (
        $changed(o_sclk) && !(&o_sel_n) |=> $stable(o_mosi))
        else $error("data moved without clock edge");
    a_sclk_half_min: assert property (
        $changed(o_sclk) |=> $stable(o_sclk)) else $error("clock half period short");
    a_read_pulse: assert property (
        i_rd |=> o_rd_valid ##1 !o_rd_valid) else $error("read answer wrong");
endmodule // smp_spi_sva

bind smp_spi_master_port smp_spi_sva u_smp_spi_sva (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_rd(i_rd),
    .i_addr(i_addr),
    .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid),
    .o_sclk(o_sclk),
    .o_mosi(o_mosi),
    .o_sel_n(o_sel_n),
    .o_irq_req(o_irq_req)
);
`default_nettype wire

// ==== testbench/smp_spi_periph.sv ====
/* Behavioural serial peripheral: sends a fixed word, records what it gets.
   Assumes one select line (any select low) and the phase bit of the master. */
`timescale 1ns/1ps
`default_nettype none
module smp_spi_periph #(
    parameter logic [31:0] TX_WORD = 32'h9c3e_51a7
) (
    // Serial side
    input wire logic i_sclk,
    input wire logic i_mosi,
    input wire logic i_sel_n,
    input wire logic i_cpha,
    output logic o_miso,
    // Observation
    output logic [31:0] o_rx,
    output logic [5:0] o_cnt
);
    logic [4:0] idx;
    initial begin
        o_miso = 1'b0;
        o_rx = 32'h0;
        o_cnt = 6'h0;
        idx = 5'h0;
    end
    // First bit is ready as soon as the select falls
    always @(negedge i_sel_n) begin
        idx = 5'h0;
        o_cnt = 6'h0;
        o_miso = TX_WORD[31];
    end
    // A released line shows the inverse of its last bit
    always @(posedge i_sel_n) o_miso = ~o_miso;
    always @(i_sclk) begin
        if (i_sel_n === 1'b0) begin
            if ((i_sclk ^ i_cpha) === 1'b1) begin
                o_rx = {o_rx[30:0], i_mosi};
                o_cnt = o_cnt + 6'h1;
            end else if (o_cnt != 6'h0) begin
                // No shift before the first sample of a frame
                idx = idx + 5'h1;
                o_miso = TX_WORD[5'd31 - idx];
            end
        end
    end
endmodule // smp_spi_periph
`default_nettype wire

// ==== testbench/tb.sv ====
/* Self-checking bench for the serial master port.
   Assumes the peripheral model answers on any select. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] TXW = 32'h9c3e_51a7;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_periph_irq_n = 1'b1;
    logic cpha = 1'b0;
    logic o_wr_ready, o_rd_valid, o_sclk, o_mosi, miso;
    logic [7:0] o_rdata;
    logic [6:0] o_sel_n;
    logic [3:0] o_irq_req;
    logic [31:0] m_rx;
    logic [5:0] m_cnt;
    logic [7:0] rv;
    logic sclk_q = 1'b0;
    int fails = 0;
    int check_count = 0;
    int gap = 0;
    int n_edge = 0;
    int half = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;

    smp_spi_master_port u_smp_spi_master_port (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_wr_ready(o_wr_ready), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
        .o_sclk(o_sclk), .o_mosi(o_mosi), .i_miso(miso), .o_sel_n(o_sel_n),
        .i_periph_irq_n(i_periph_irq_n), .o_irq_req(o_irq_req));
    smp_spi_periph #(.TX_WORD(TXW)) u_smp_spi_periph (.i_sclk(o_sclk), .i_mosi(o_mosi),
        .i_sel_n(&o_sel_n), .i_cpha(cpha), .o_miso(miso), .o_rx(m_rx), .o_cnt(m_cnt));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(negedge i_ref_clk);
        for (int k = 0; k < 5000 && o_wr_ready !== 1'b1; k++) @(negedge i_ref_clk);
        if (o_wr_ready !== 1'b1) chk(o_wr_ready, 1'b1);
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(negedge i_ref_clk);
        rv = o_rdata;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        rd(a);
        chk(rv, e);
    endtask

    task automatic wait_idle();
        rd(smp_pkg::OFS_STAT);
        for (int k = 0; k < 3000 && rv[0] !== 1'b0; k++) rd(smp_pkg::OFS_STAT);
        chk(rv[0], 1'b0);
    endtask

    // Edge spacing inside a frame
    always @(posedge i_ref_clk) begin
        sclk_q <= o_sclk;
        if (&o_sel_n) n_edge <= 0;
        else if (o_sclk !== sclk_q) begin
            if (n_edge != 0) chk(32'(gap), 32'(half));
            n_edge <= n_edge + 1;
        end
        gap <= (o_sclk !== sclk_q) ? 1 : gap + 1;
    end

    task automatic xfer(input logic [7:0] c, input logic [7:0] s, input logic [7:0] dbg,
                        input logic [31:0] w);
        logic [31:0] em;
        logic [31:0] er;
        logic mb;
        int n;
        n = 8 * (c[5:4] + 1);
        half = smp_pkg::DIV_CODE0 >> (s[5:4] + 1);
        em = 32'h0;
        er = w;
        for (int i = 0; i < n; i++) begin
            mb = s[2] ? w[32 - n + i] : w[31 - i];
            em = {em[30:0], mb};
            if (s[2]) er[32 - n + i] = dbg[1] ? mb : TXW[31 - i];
            else er[31 - i] = dbg[1] ? mb : TXW[31 - i];
        end
        cpha <= c[6];
        wr(smp_pkg::OFS_DEBUG, dbg);
        wr(smp_pkg::OFS_CTRL, c);
        wr(smp_pkg::OFS_STAT, s);
        for (int b = 0; b < 4; b++) wr(smp_pkg::OFS_DATA0 + b[3:0], w[8*b +: 8]);
        wait_idle();
        chk(o_sclk, c[7]);
        chk(m_cnt, n[5:0]);
        chk(m_rx & (32'hffff_ffff >> (32 - n)), em);
        for (int b = 0; b < 4; b++) rdchk(smp_pkg::OFS_DATA0 + b[3:0], er[8*b +: 8]);
    endtask

    task automatic t_reset();
        @(negedge i_ref_clk);
        chk(o_sel_n, 7'h7f);
        chk(o_sclk, 1'b0);
        rdchk(smp_pkg::OFS_STAT, 8'h00);
        rdchk(smp_pkg::OFS_DEBUG, 8'h00);
        for (int b = 0; b < 4; b++) rdchk(smp_pkg::OFS_DATA0 + b[3:0], 8'h00);
    endtask

    task automatic t_regs();
        @(posedge i_ref_clk);
        i_periph_irq_n <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(smp_pkg::OFS_STAT, {k[1:0], 6'h3f});
            rdchk(smp_pkg::OFS_STAT, {k[1:0], 6'h3c});
            chk(o_irq_req, 4'h0);
        end
        @(posedge i_ref_clk);
        i_periph_irq_n <= 1'b1;
        wr(smp_pkg::OFS_DEBUG, 8'hff);
        rdchk(smp_pkg::OFS_DEBUG, 8'h02);
        wr(4'h0, 8'h5a);
        rdchk(4'h0, 8'h00);
        wr(smp_pkg::OFS_DATA0, 8'ha5);
        rdchk(smp_pkg::OFS_DATA0, 8'ha5);
    endtask

    task automatic t_manual();
        logic [6:0] es;
        for (int k = 0; k < 8; k++) begin
            es = (k == 0) ? 7'h7f : ~(7'h01 << (k - 1));
            wr(smp_pkg::OFS_CTRL, {5'h01, k[2:0]});
            repeat (3) @(negedge i_ref_clk);
            chk(o_sel_n, es);
        end
    endtask

    task automatic t_frames();
        for (int k = 0; k < 4; k++) xfer({2'b00, k[1:0], 4'h1}, 8'h30, 8'h00, 32'h1234_5678 ^ k);
        for (int k = 0; k < 3; k++) xfer(8'h01, {2'b00, k[1:0], 4'h0}, 8'h00, 32'ha5c3_0f96);
        xfer(8'h22, 8'h34, 8'h00, 32'h0f1e_2d3c);
        xfer(8'hd3, 8'h34, 8'h00, 32'h8421_c3f0);
        xfer(8'h35, 8'h30, 8'h02, 32'h6b2d_9e47);
        // Manual select frame, then the two phase modes whose first edge shifts
        xfer(8'h19, 8'h30, 8'h00, 32'h3c5a_96e1);
        xfer(8'h51, 8'h30, 8'h00, 32'hd2b4_7e18);
        xfer(8'h81, 8'h34, 8'h00, 32'h4e7d_a235);
    endtask

    task automatic t_fifo();
        cpha <= 1'b0;
        half = smp_pkg::DIV_CODE0 / 2;
        wr(smp_pkg::OFS_CTRL, 8'h31);
        wr(smp_pkg::OFS_STAT, 8'h00);
        wr(smp_pkg::OFS_DATA3, 8'h5a);
        for (int k = 0; k < 8; k++) wr(smp_pkg::OFS_CTRL, 8'h30);
        @(negedge i_ref_clk);
        chk(o_wr_ready, 1'b0);
        wait_idle();
        chk(o_wr_ready, 1'b1);
        rdchk(smp_pkg::OFS_CTRL, 8'h30);
    endtask

    task automatic results();
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_manual();
        t_frames();
        t_fifo();
        results();
    end

    initial begin
        #500000;
        fails++;
        results();
    end
endmodule // tb
`default_nettype wire
